// *** src/ucf_consts.vh ***
// Constants for the UART channel format and FIFO control block.
// Assumes word-aligned Wishbone access: byte address = 4 * register index.
`ifndef UCF_CONSTS_VH
`define UCF_CONSTS_VH

// ****************************************
// Register indices
// ****************************************
`define UCF_IDX_DATA 3'h0
`define UCF_IDX_IER  3'h1
`define UCF_IDX_ISR  3'h2
`define UCF_IDX_LCR  3'h3
`define UCF_IDX_MCR  3'h4
`define UCF_IDX_STAT 3'h5
`define UCF_IDX_FEATURE_CONTROL 3'h6

// ****************************************
// Field positions
// ****************************************
`define UCF_FCR_EN    0
`define UCF_FCR_RXRST 1
`define UCF_FCR_TXRST 2
`define UCF_FCR_DMA   3
`define UCF_LCR_DLAB  7
`define UCF_LCR_BRK   6
`define UCF_LCR_FPAR  5
`define UCF_LCR_EVEN  4
`define UCF_LCR_PEN   3
`define UCF_LCR_STOP  2
`define UCF_MCR_PRE   7
`define UCF_MCR_IR    6
`define UCF_MCR_XANY  5
`define UCF_MCR_LOOP  4
`define UCF_FEATURE_CONTROL_HOLD 0
`define UCF_FEATURE_CONTROL_RINV 4
`define UCF_FEATURE_CONTROL_TAB  7

// ****************************************
// Interrupt source codes, status bits 5:1
// ****************************************
`define UCF_ISR_LSR  5'h03
`define UCF_ISR_RXRD 5'h02
`define UCF_ISR_TXRD 5'h01
`define UCF_ISR_NONE 5'h00

// ****************************************
// Reset values and timing in oversample ticks
// ****************************************
`define UCF_LCR_RST  8'h00
`define UCF_MCR_RST  8'h00
`define UCF_FEATURE_CONTROL_RST 8'h00
`define UCF_DIV_RST  16'h0001
`define UCF_BIT_LAST 5'h0F
`define UCF_MID_LAST 5'h07
`define UCF_STOP15   5'h17
`define UCF_STOP2    5'h1F
`define UCF_IR_PULSE 5'h03
`define UCF_IR_HOLD  5'h10

`endif

// *** src/ucf_fifo.v ***
// Byte FIFO held in flip-flops, used for both directions of a channel.
// Assumes the caller never writes when full nor reads when empty.
`timescale 1ns/1ns
`default_nettype none

module ucf_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // Control
  input  wire          clr_i,
  input  wire          wr_i,
  input  wire [W-1:0]  wdat_i,
  input  wire          rd_i,
  // Status
  output wire [W-1:0]  rdat_o,
  output wire [AW:0]   cnt_o
);

  reg [W-1:0]  mem_ff [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  reg [AW:0]   cnt_ff;

  assign rdat_o = mem_ff[rptr_ff];
  assign cnt_o  = cnt_ff;

  // Clear touches pointers and count only; stored bytes are left as junk
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff  <= {(AW+1){1'b0}};
    end else begin
      if (wr_i) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (rd_i) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      if (wr_i && !rd_i) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (rd_i && !wr_i) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (wr_i && !clr_i) begin
      mem_ff[wptr_ff] <= wdat_i;
    end
  end

endmodule // ucf_fifo

`default_nettype wire

// *** src/ucf_channel.v ***
// One UART channel: Wishbone register file, FIFOs, framer and IR codec.
// Assumes a classic Wishbone master and serial inputs synchronous to clk_i.
// Operation
// - Status bits 7:6 mirror FIFO enable
// - Status bits 5:1 give highest source
// - Only highest pending level shown, others wait
// - Status bit 0 low while interrupt pending
// - FIFO setup write-only, bit 0 gates others
// - Receive trigger sets receive interrupt threshold
// - Transmit interrupt below trigger or on empty
// - Last trigger write picks table for both
// - DMA bit stored, no effect
// - Transmit FIFO reset clears pointers, self-clears
// - Receive FIFO reset clears pointers, self-clears
// - Line format bit 7 selects divisor registers
// - Break bit holds transmit line at space
// - Parity enable bit adds and checks parity
// - Bit 4 picks odd or even parity
// - Bit 5 forces parity to inverse bit 4
// - Stop bits: one, one-and-half or two
// - Low two bits set five to eight bits
// - Prescaler divides baud clock by one or four
// - Infrared enable loads strap after reset
// - Infrared mode routes through codec, idles low
// - Feature bit inverts receive before IR decoder
// - Xon-any: any received char resumes transmit
// - Modem bit 4 selects local loopback
`timescale 1ns/1ns
`default_nettype none
`include "ucf_consts.vh"

module ucf_channel #(
  parameter        DEPTH    = 16,
  parameter        AW       = 4,
  parameter [31:0] RX_TAB_A = 32'h0E080401,
  parameter [31:0] TX_TAB_A = 32'h0C080401,
  parameter [31:0] RX_TAB_B = 32'h0F0C0801,
  parameter [31:0] TX_TAB_B = 32'h0E0C0801
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [4:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Serial line and strap
  input  wire        serial_rx_i,
  input  wire        infrared_strap_pin_i,
  output reg         serial_tx_o
);

  localparam CW = AW + 1;
  localparam [2:0] S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h2,
                   S_PAR = 3'h3, S_STOP = 3'h4;

  // ****************************************
  // Functions
  // ****************************************
  function [7:0] trig_lvl;
    input [31:0] tab;
    input [1:0]  s;
    begin
      trig_lvl = tab[{s, 3'b000} +: 8];
    end
  endfunction

  function par_of;
    input [7:0] d;
    input [7:0] line_format;
    reg   [7:0] m;
    begin
      m = d & (8'hFF >> (2'h3 - line_format[1:0]));
      if (line_format[`UCF_LCR_FPAR])
        par_of = ~line_format[`UCF_LCR_EVEN];
      else if (line_format[`UCF_LCR_EVEN])
        par_of = ^m;
      else
        par_of = ~^m;
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [2:0]  ier_ff;
  reg [7:0]  lcr_ff;
  reg [7:0]  mcr_ff;
  reg [7:0]  feature_control_ff;
  reg [15:0] div_ff;
  reg [3:0]  div_fr_ff;
  reg        fifo_en_ff;
  reg [1:0]  rx_trig_ff;
  reg [1:0]  tx_trig_ff;
  reg        tab_ff;
  reg        dma_ff;
  reg        strap_pend_ff;
  reg        perr_ff;
  reg        ferr_ff;
  reg        oerr_ff;
  reg        txint_ff;
  reg        tx_above_ff;
  reg        suspend_ff;
  reg [CW-1:0] tx_prev_ff;
  reg [1:0]  pre_ff;
  reg [15:0] baud_ff;
  reg        tick_ff;
  reg [2:0]  tx_st_ff;
  reg [7:0]  tx_sh_ff;
  reg [2:0]  tx_bit_ff;
  reg [4:0]  tx_ph_ff;
  reg        tx_par_ff;
  reg        tx_line_ff;
  reg [2:0]  rx_st_ff;
  reg [7:0]  rx_sh_ff;
  reg [2:0]  rx_bit_ff;
  reg [4:0]  rx_ph_ff;
  reg [4:0]  ir_hold_ff;
  reg        rx_push_ff;
  reg [7:0]  rx_dat_ff;
  reg        rx_perr_ff;
  reg        rx_ferr_ff;

  wire [CW-1:0] rx_cnt;
  wire [CW-1:0] tx_cnt;
  wire [7:0]    rx_head;
  wire [7:0]    tx_head;
  wire [7:0]    rx_cnt8 = {{(8-CW){1'b0}}, rx_cnt};
  wire [7:0]    tx_cnt8 = {{(8-CW){1'b0}}, tx_cnt};
  wire [7:0]    prev8   = {{(8-CW){1'b0}}, tx_prev_ff};

  // ****************************************
  // Bus decode
  // ****************************************
  wire       req    = wb_cyc_i & wb_stb_i;
  wire       acc    = req & wb_ack_o;
  wire       wr_acc = acc & wb_we_i & wb_sel_i[0];
  wire       rd_acc = acc & ~wb_we_i;
  wire [2:0] idx    = wb_adr_i[4:2];
  wire [7:0] wd     = wb_dat_i[7:0];
  wire       dlab   = lcr_ff[`UCF_LCR_DLAB];
  wire       sel_data = (idx == `UCF_IDX_DATA) & ~dlab;
  wire       sel_isr  = (idx == `UCF_IDX_ISR) & ~dlab;

  // Without FIFOs both directions behave as one-byte holding registers
  wire [CW-1:0] lim = fifo_en_ff ? DEPTH[CW-1:0] : {{(CW-1){1'b0}}, 1'b1};
  wire [31:0] rx_tab = tab_ff ? RX_TAB_B : RX_TAB_A;
  wire [31:0] tx_tab = tab_ff ? TX_TAB_B : TX_TAB_A;
  wire [7:0]  rx_lvl = fifo_en_ff ? trig_lvl(rx_tab, rx_trig_ff) : 8'h01;
  wire [7:0]  tx_lvl = fifo_en_ff ? trig_lvl(tx_tab, tx_trig_ff) : 8'h01;

  wire tx_push = wr_acc & sel_data & (tx_cnt < lim);
  wire rx_pop  = rd_acc & sel_data & (rx_cnt != {CW{1'b0}});
  wire fcr_wr  = wr_acc & sel_isr & wd[`UCF_FCR_EN];
  wire tx_clr  = fcr_wr & wd[`UCF_FCR_TXRST];
  wire rx_clr  = fcr_wr & wd[`UCF_FCR_RXRST];

  // ****************************************
  // Interrupt priority
  // ****************************************
  wire src_lsr = ier_ff[2] & (perr_ff | ferr_ff | oerr_ff);
  wire src_rx  = ier_ff[0] & (rx_cnt != {CW{1'b0}}) &
                 (rx_cnt8 >= rx_lvl);
  wire src_tx  = ier_ff[1] & txint_ff;
  reg  [4:0] isr_code;
  always @* begin
    if (src_lsr)
      isr_code = `UCF_ISR_LSR;
    else if (src_rx)
      isr_code = `UCF_ISR_RXRD;
    else if (src_tx)
      isr_code = `UCF_ISR_TXRD;
    else
      isr_code = `UCF_ISR_NONE;
  end
  wire       pend     = src_lsr | src_rx | src_tx;
  wire [7:0] isr_val  = {{2{fifo_en_ff}}, isr_code, ~pend};

  // Transmit interrupt events
  wire tx_fall  = (prev8 >= tx_lvl) & (tx_cnt8 < tx_lvl);
  wire tx_empty = (tx_cnt == {CW{1'b0}}) &
                  (tx_prev_ff != {CW{1'b0}}) & ~tx_above_ff;
  wire tx_ev    = tx_fall | tx_empty;
  wire tx_ack   = (rd_acc & sel_isr & (isr_code == `UCF_ISR_TXRD)) |
                  (wr_acc & sel_data);

  // ****************************************
  // Read mux and Wishbone answer
  // ****************************************
  reg [7:0] rd_mux;
  always @* begin
    case (idx)
      `UCF_IDX_DATA: rd_mux = dlab ? div_ff[7:0] : rx_head;
      `UCF_IDX_IER:  rd_mux = dlab ? div_ff[15:8] : {5'h00, ier_ff};
      `UCF_IDX_ISR:  rd_mux = dlab ? {4'h0, div_fr_ff} : isr_val;
      `UCF_IDX_LCR:  rd_mux = lcr_ff;
      `UCF_IDX_MCR:  rd_mux = mcr_ff;
      `UCF_IDX_STAT: rd_mux = {dma_ff, tab_ff, suspend_ff,
                               tx_cnt == {CW{1'b0}}, oerr_ff, ferr_ff,
                               perr_ff, rx_cnt != {CW{1'b0}}};
      `UCF_IDX_FEATURE_CONTROL: rd_mux = feature_control_ff;
      default:       rd_mux = 8'h00;
    endcase
  end

  // Answer one cycle after the strobe; ack drops in the following cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o & ~wb_we_i)
        wb_dat_o <= {24'h000000, rd_mux};
    end
  end

  // ****************************************
  // Control registers and sticky flags
  // ****************************************
  wire stat_rd = rd_acc & (idx == `UCF_IDX_STAT);
  always @(posedge clk_i) begin
    if (rst_i) begin
      ier_ff        <= 3'h0;
      lcr_ff        <= `UCF_LCR_RST;
      mcr_ff        <= `UCF_MCR_RST;
      feature_control_ff       <= `UCF_FEATURE_CONTROL_RST;
      div_ff        <= `UCF_DIV_RST;
      div_fr_ff     <= 4'h0;
      fifo_en_ff    <= 1'b0;
      rx_trig_ff    <= 2'h0;
      tx_trig_ff    <= 2'h0;
      tab_ff        <= 1'b0;
      dma_ff        <= 1'b0;
      strap_pend_ff <= 1'b1;
      perr_ff       <= 1'b0;
      ferr_ff       <= 1'b0;
      oerr_ff       <= 1'b0;
      txint_ff      <= 1'b0;
      tx_above_ff   <= 1'b0;
      suspend_ff    <= 1'b0;
      tx_prev_ff    <= {CW{1'b0}};
    end else begin
      strap_pend_ff <= 1'b0;
      tx_prev_ff    <= tx_cnt;
      if (strap_pend_ff)
        mcr_ff[`UCF_MCR_IR] <= infrared_strap_pin_i;
      if (wr_acc) begin
        case (idx)
          `UCF_IDX_DATA: if (dlab) div_ff[7:0] <= wd;
          `UCF_IDX_IER: begin
            if (dlab) div_ff[15:8] <= wd;
            else ier_ff <= wd[2:0];
          end
          `UCF_IDX_ISR: begin
            if (dlab) begin
              div_fr_ff <= wd[3:0];
            end else begin
              fifo_en_ff <= wd[`UCF_FCR_EN];
              if (wd[`UCF_FCR_EN]) begin
                dma_ff     <= wd[`UCF_FCR_DMA];
                tx_trig_ff <= wd[5:4];
                rx_trig_ff <= wd[7:6];
                tab_ff     <= feature_control_ff[`UCF_FEATURE_CONTROL_TAB];
              end
            end
          end
          `UCF_IDX_LCR:  lcr_ff <= wd;
          `UCF_IDX_MCR:  if (!strap_pend_ff) mcr_ff <= wd;
          `UCF_IDX_FEATURE_CONTROL: feature_control_ff <= wd;
          default: ;
        endcase
      end
      // Software sets hold; a received char with xon-any releases it
      if (wr_acc && idx == `UCF_IDX_FEATURE_CONTROL && wd[`UCF_FEATURE_CONTROL_HOLD])
        suspend_ff <= 1'b1;
      else if (rx_push_ff && mcr_ff[`UCF_MCR_XANY])
        suspend_ff <= 1'b0;
      else if (wr_acc && idx == `UCF_IDX_FEATURE_CONTROL)
        suspend_ff <= 1'b0;
      // Hardware set wins over a clearing read in the same cycle
      perr_ff <= rx_perr_ff | (perr_ff & ~stat_rd);
      ferr_ff <= rx_ferr_ff | (ferr_ff & ~stat_rd);
      oerr_ff <= (rx_push_ff & (rx_cnt >= lim)) | (oerr_ff & ~stat_rd);
      txint_ff <= tx_ev | (txint_ff & ~tx_ack);
      if (tx_cnt8 > tx_lvl)
        tx_above_ff <= 1'b1;
      else if (tx_cnt == {CW{1'b0}})
        tx_above_ff <= 1'b0;
    end
  end

  // ****************************************
  // Baud tick: prescaler then divisor, 16 ticks per bit
  // ****************************************
  wire pre_en = mcr_ff[`UCF_MCR_PRE] ? (pre_ff == 2'h3) : 1'b1;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_ff  <= 2'h0;
      baud_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= pre_ff + 2'h1;
      tick_ff <= 1'b0;
      if (pre_en) begin
        if (baud_ff + 16'h0001 >= div_ff) begin
          baud_ff <= 16'h0000;
          tick_ff <= 1'b1;
        end else begin
          baud_ff <= baud_ff + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  wire [2:0] wlast = {1'b1, lcr_ff[1:0]};
  wire [4:0] stop_last = ~lcr_ff[`UCF_LCR_STOP] ? `UCF_BIT_LAST :
                         (lcr_ff[1:0] == 2'h0) ? `UCF_STOP15 :
                         `UCF_STOP2;
  wire tx_pop = tick_ff & (tx_st_ff == S_IDLE) &
                (tx_cnt != {CW{1'b0}}) & ~suspend_ff;
  wire tx_end = (tx_ph_ff == `UCF_BIT_LAST);

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_ff   <= S_IDLE;
      tx_sh_ff   <= 8'h00;
      tx_bit_ff  <= 3'h0;
      tx_ph_ff   <= 5'h00;
      tx_par_ff  <= 1'b0;
      tx_line_ff <= 1'b1;
    end else if (tick_ff) begin
      tx_ph_ff <= tx_ph_ff + 5'h01;
      case (tx_st_ff)
        S_IDLE: begin
          tx_line_ff <= 1'b1;
          if (tx_pop) begin
            tx_sh_ff   <= tx_head;
            tx_par_ff  <= par_of(tx_head, lcr_ff);
            tx_line_ff <= 1'b0;
            tx_ph_ff   <= 5'h00;
            tx_st_ff   <= S_START;
          end
        end
        S_START: if (tx_end) begin
          tx_line_ff <= tx_sh_ff[0];
          tx_bit_ff  <= 3'h0;
          tx_ph_ff   <= 5'h00;
          tx_st_ff   <= S_DATA;
        end
        S_DATA: if (tx_end) begin
          tx_ph_ff <= 5'h00;
          if (tx_bit_ff == wlast) begin
            tx_line_ff <= lcr_ff[`UCF_LCR_PEN] ? tx_par_ff : 1'b1;
            tx_st_ff   <= lcr_ff[`UCF_LCR_PEN] ? S_PAR : S_STOP;
          end else begin
            tx_line_ff <= tx_sh_ff[tx_bit_ff + 3'h1];
            tx_bit_ff  <= tx_bit_ff + 3'h1;
          end
        end
        S_PAR: if (tx_end) begin
          tx_line_ff <= 1'b1;
          tx_ph_ff   <= 5'h00;
          tx_st_ff   <= S_STOP;
        end
        S_STOP: if (tx_ph_ff == stop_last - 5'h01) begin
          tx_st_ff <= S_IDLE;
        end
        default: tx_st_ff <= S_IDLE;
      endcase
    end
  end

  // Encoder sends a short high pulse for each zero bit, idles low
  wire ir_on   = mcr_ff[`UCF_MCR_IR];
  wire loop_on = mcr_ff[`UCF_MCR_LOOP];
  wire ir_enc  = ~tx_line_ff & (tx_ph_ff < `UCF_IR_PULSE);
  always @(posedge clk_i) begin
    if (rst_i)
      serial_tx_o <= 1'b1;
    else if (lcr_ff[`UCF_LCR_BRK])
      serial_tx_o <= 1'b0;
    else if (loop_on)
      serial_tx_o <= ~ir_on;
    else if (ir_on)
      serial_tx_o <= ir_enc;
    else
      serial_tx_o <= tx_line_ff;
  end

  // ****************************************
  // Receiver
  // ****************************************
  wire rx_pin = serial_rx_i ^ feature_control_ff[`UCF_FEATURE_CONTROL_RINV];
  wire ir_dec = (ir_hold_ff == 5'h00);
  wire rx_in  = loop_on ? tx_line_ff :
                ir_on ? ir_dec : serial_rx_i;
  wire rx_end = (rx_ph_ff == `UCF_BIT_LAST);

  // Decoder stretches each received pulse into a full low bit
  always @(posedge clk_i) begin
    if (rst_i)
      ir_hold_ff <= 5'h00;
    else if (rx_pin)
      ir_hold_ff <= `UCF_IR_HOLD;
    else if (tick_ff && ir_hold_ff != 5'h00)
      ir_hold_ff <= ir_hold_ff - 5'h01;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_ff   <= S_IDLE;
      rx_sh_ff   <= 8'h00;
      rx_bit_ff  <= 3'h0;
      rx_ph_ff   <= 5'h00;
      rx_push_ff <= 1'b0;
      rx_dat_ff  <= 8'h00;
      rx_perr_ff <= 1'b0;
      rx_ferr_ff <= 1'b0;
    end else begin
      rx_push_ff <= 1'b0;
      rx_perr_ff <= 1'b0;
      rx_ferr_ff <= 1'b0;
      if (tick_ff) begin
        rx_ph_ff <= rx_ph_ff + 5'h01;
        case (rx_st_ff)
          S_IDLE: if (!rx_in) begin
            rx_ph_ff <= 5'h00;
            rx_sh_ff <= 8'h00;
            rx_st_ff <= S_START;
          end
          S_START: if (rx_ph_ff == `UCF_MID_LAST) begin
            rx_ph_ff  <= 5'h00;
            rx_bit_ff <= 3'h0;
            rx_st_ff  <= rx_in ? S_IDLE : S_DATA;
          end
          S_DATA: if (rx_end) begin
            rx_ph_ff            <= 5'h00;
            rx_sh_ff[rx_bit_ff] <= rx_in;
            rx_bit_ff           <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == wlast)
              rx_st_ff <= lcr_ff[`UCF_LCR_PEN] ? S_PAR : S_STOP;
          end
          S_PAR: if (rx_end) begin
            rx_ph_ff   <= 5'h00;
            rx_perr_ff <= (rx_in != par_of(rx_sh_ff, lcr_ff));
            rx_st_ff   <= S_STOP;
          end
          S_STOP: if (rx_end) begin
            rx_ferr_ff <= ~rx_in;
            rx_dat_ff  <= rx_sh_ff;
            rx_push_ff <= 1'b1;
            rx_st_ff   <= S_IDLE;
          end
          default: rx_st_ff <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  ucf_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (tx_clr),
    .wr_i   (tx_push),
    .wdat_i (wd),
    .rd_i   (tx_pop),
    .rdat_o (tx_head),
    .cnt_o  (tx_cnt)
  );

  // Overrun drops the new byte so stored data stays intact
  ucf_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (rx_clr),
    .wr_i   (rx_push_ff & (rx_cnt < lim)),
    .wdat_i (rx_dat_ff),
    .rd_i   (rx_pop),
    .rdat_o (rx_head),
    .cnt_o  (rx_cnt)
  );

endmodule // ucf_channel

`default_nettype wire

// *** sim/ucf_chk_assertions.sv ***
// Checker for the channel's bus answers and line levels.
// Assumes word-aligned access and a strap held steady around reset.
`timescale 1ns/1ns
`default_nettype none

module ucf_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Line
  input wire logic        serial_rx_i,
  input wire logic        infrared_strap_pin_i,
  input wire logic        serial_tx_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] lcr_ff;
  logic [7:0] mcr_ff;
  logic       fen_ff;
  logic       rst_q_ff;
  logic [1:0] stab_ff;
  wire        wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire        rd = wb_ack_o & ~wb_we_i;
  wire [2:0]  idx = wb_adr_i[4:2];
  wire        rd_isr = rd & (idx == 3'h2) & ~lcr_ff[7];

  // Shadow copies; stab_ff lets the registered line settle first
  always @(posedge clk_i) begin
    rst_q_ff <= rst_i;
    if (rst_i) begin
      lcr_ff <= 8'h00;
      mcr_ff <= 8'h00;
      fen_ff <= 1'b0;
      stab_ff <= 2'h0;
    end else begin
      stab_ff <= (stab_ff == 2'h3) ? 2'h3 : stab_ff + 2'h1;
      if (rst_q_ff) begin
        mcr_ff[6] <= infrared_strap_pin_i;
        stab_ff <= 2'h0;
      end
      if (wr) begin
        stab_ff <= 2'h0;
        if (idx == 3'h3) lcr_ff <= wb_dat_i[7:0];
        if (idx == 3'h4) mcr_ff <= wb_dat_i[7:0];
        if (idx == 3'h2 && !lcr_ff[7]) fen_ff <= wb_dat_i[0];
      end
    end
  end

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  isr_fifo_bits_a: assert property (rd_isr |-> wb_dat_o[7:6] == {2{fen_ff}})
    else $error("status top bits disagree with fifo enable");
  isr_code_a: assert property (rd_isr |->
    wb_dat_o[5:0] inside {6'h06, 6'h04, 6'h02, 6'h01})
    else $error("illegal interrupt code");
  lcr_back_a: assert property (rd && idx == 3'h3 |-> wb_dat_o == {24'h0, lcr_ff})
    else $error("line format readback wrong");
  unmapped_zero_a: assert property (rd && idx == 3'h7 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  break_space_a: assert property (stab_ff == 2'h3 && lcr_ff[6] && !mcr_ff[4]
    |-> !serial_tx_o) else $error("break not holding space");
  loop_idle_a: assert property (stab_ff == 2'h3 && mcr_ff[4] && !lcr_ff[6]
    |-> serial_tx_o == !mcr_ff[6]) else $error("loopback pin not idle");

  cover property (rd_isr && wb_dat_o[2]);
  cover property (stab_ff == 2'h3 && mcr_ff[4]);
  cover property (stab_ff == 2'h3 && lcr_ff[6]);
endmodule // ucf_chk

bind ucf_channel ucf_chk CHK (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .serial_rx_i(serial_rx_i),
  .infrared_strap_pin_i(infrared_strap_pin_i), .serial_tx_o(serial_tx_o));
`default_nettype wire

// *** sim/ucf_remote.sv ***
// Remote serial transceiver: sends 8N1 characters and samples frames.
// Assumes a bit lasts a fixed count of clk_i cycles (divisor one).
`timescale 1ns/1ns
`default_nettype none

module ucf_remote (
  // Clock
  input  wire logic clk_i,
  // Serial line
  input  wire logic line_i,
  output var  logic line_o
);
  // Starts at the infrared idle level; the bench raises it to mark
  initial line_o = 1'b0;

  // Mark is the idle level, so the line rests high between characters
  task automatic send(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= fr[i];
      repeat (15) @(posedge clk_i);
    end
  endtask

  // Samples n bits plus stop, then times start to next start
  task automatic grab(input int n, input int cpb, output logic [31:0] bits,
                      output int per);
    int t;
    bits = 32'h0;
    t = 0;
    while (line_i !== 1'b0 && t < 5000) begin
      @(posedge clk_i);
      t++;
    end
    repeat (cpb / 2) @(posedge clk_i);
    per = cpb / 2;
    for (int i = 0; i <= n; i++) begin
      repeat (cpb) @(posedge clk_i);
      per += cpb;
      bits[i] = line_i;
    end
    while (line_i !== 1'b0 && per < 5000) begin
      @(posedge clk_i);
      per++;
    end
  endtask
endmodule // ucf_remote
`default_nettype wire

// *** sim/uart_channel_format_fifo_control_bench.sv ***
// Self-checking bench for one UART channel over classic Wishbone.
// Assumes the remote model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module uart_channel_format_fifo_control_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        rxl;
  logic        txl;
  logic [7:0]  q;
  int          err_count = 0;
  int          n_checks = 0;

  always #5 clk_i = ~clk_i;

  ucf_channel DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_rx_i(rxl),
    .infrared_strap_pin_i(1'b1), .serial_tx_o(txl));
  ucf_remote REM (.clk_i(clk_i), .line_i(txl), .line_o(rxl));

  task results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  task acc(input logic [2:0] a, input logic w, input logic [7:0] d);
    int t;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 2'b00, 24'h0, d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      err_count++;
      results();
    end
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask

  task rdc(input logic [2:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk($sformatf("register %0d", a), {24'h0, e}, {24'h0, q});
  endtask

  task t_regs();
    rdc(2, 8'h01);
    rdc(3, 8'h00);
    rdc(4, 8'h40);
    chk("tx idle", 32'h0, {31'h0, txl});
    rdc(7, 8'h00);
    acc(4, 1, 8'h00);
    REM.line_o <= 1'b1;
    acc(3, 1, 8'h3F);
    rdc(3, 8'h3F);
    acc(3, 1, 8'h80);
    rdc(0, 8'h01);
    acc(2, 1, 8'h05);
    rdc(2, 8'h05);
    acc(3, 1, 8'h00);
    acc(2, 1, 8'hC8);
    rdc(5, 8'h10);
    acc(2, 1, 8'h09);
    rdc(5, 8'h90);
    rdc(2, 8'hC1);
    acc(2, 1, 8'h00);
    rdc(2, 8'h01);
    $display("t_regs done");
  endtask

  task t_frames();
    logic [7:0]  f [5];
    logic [31:0] b;
    logic [31:0] e;
    logic [7:0]  dm;
    logic        par;
    int          nb, pn, per, cpb, sp;
    f = '{8'h1B, 8'h0A, 8'h2C, 8'h3D, 8'h03};
    acc(2, 1, 8'h07);
    for (int i = 0; i < 5; i++) begin
      cpb = (i == 4) ? 64 : 16;
      acc(4, 1, {i == 4, 7'h00});
      acc(3, 1, f[i]);
      nb = 5 + f[i][1:0];
      pn = f[i][3];
      dm = 8'hA5 & ~(8'hFF << nb);
      par = f[i][5] ? ~f[i][4] : (f[i][4] ? ^dm : ~^dm);
      sp = !f[i][2] ? cpb : (nb == 5 ? cpb * 3 / 2 : cpb * 2);
      e = {24'h0, dm} | (pn ? {31'h0, par} << nb : 32'h0) | (32'h1 << (nb + pn));
      fork
        REM.grab(nb + pn, cpb, b, per);
        begin
          acc(0, 1, 8'hA5);
          acc(0, 1, 8'hA5);
        end
      join
      chk("frame bits", e, b);
      chk("frame period", 32'(cpb * (1 + nb + pn) + sp), 32'(per));
      repeat (13 * cpb) @(posedge clk_i);
    end
    acc(4, 1, 8'h00);
    $display("t_frames done");
  endtask

  task t_irq();
    acc(3, 1, 8'h03);
    acc(2, 1, 8'h07);
    acc(1, 1, 8'h03);
    acc(2, 0, 8'h00);
    fork
      REM.send(8'h5A);
      acc(0, 1, 8'h3C);
    join
    repeat (40) @(posedge clk_i);
    rdc(2, 8'hC4);
    rdc(0, 8'h5A);
    rdc(2, 8'hC2);
    rdc(2, 8'hC1);
    REM.send(8'h11);
    repeat (40) @(posedge clk_i);
    rdc(5, 8'h11);
    acc(2, 1, 8'h03);
    rdc(5, 8'h10);
    acc(6, 1, 8'h80);
    acc(2, 1, 8'h01);
    rdc(5, 8'h50);
    acc(6, 1, 8'h81);
    acc(0, 1, 8'h77);
    rdc(5, 8'h60);
    acc(2, 1, 8'h05);
    rdc(5, 8'h70);
    acc(4, 1, 8'h20);
    REM.send(8'h22);
    repeat (40) @(posedge clk_i);
    rdc(5, 8'h51);
    rdc(0, 8'h22);
    $display("t_irq done");
  endtask

  task t_line();
    acc(3, 1, 8'h43);
    repeat (4) @(posedge clk_i);
    chk("tx break", 32'h0, {31'h0, txl});
    acc(3, 1, 8'h03);
    repeat (4) @(posedge clk_i);
    chk("tx mark", 32'h1, {31'h0, txl});
    acc(4, 1, 8'h10);
    acc(0, 1, 8'h96);
    repeat (200) @(posedge clk_i);
    rdc(0, 8'h96);
    acc(4, 1, 8'h00);
    $display("t_line done");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_frames();
    t_irq();
    t_line();
    results();
  end
endmodule // uart_channel_format_fifo_control_bench
`default_nettype wire
